// ===== design/assisted_parallel_port.sv
// Assisted parallel port: 8/16/24-bit word transfer to an external host.
// Assumes host pins are synchronous to clk; slave answers in one wait.
// Function
// - Transfer width one, two or three bytes, chosen by config bits 1:0.
// - When enabled, handshake outputs push-pull and inputs plain.
// - Latch-vacant output tells host the input latches accept data.
// - Output-word-valid pin tells host output data is waiting.
// - Host strobe, active low, latches incoming data from the pins.
// - Host output enable, active low, puts latched data on pins.
// - Strobe and output enable act only while chip select is low.
// - Valid flag set by firmware write of data0, cleared by output enable.
// - Vacant flag set by firmware read of data0, cleared by strobe.
// - Bit 4 picks valid polarity; flag and pin read opposite.
// - Bit 5 picks vacant polarity; flag and pin read opposite.
// - Host read: output enable and chip select low drive the word.
// - Output enable returning high after a read raises the interrupt.
// - Host write: strobe with chip select fills latches, clears vacant.
// - Strobe returning high after a write raises the interrupt.
// - For wide words only data0 access moves the handshake.
//
// The Avalon-MM interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module assisted_parallel_port #(
  parameter int WORD_BYTES = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Interrupt
  output logic irq,
  // Host handshake pins
  input wire logic input_strobe_n,
  input wire logic output_enable_n,
  input wire logic chip_select_n,
  output logic latch_vacant_out,
  output logic out_word_valid_pin,
  output logic handshake_oe_n,
  // Data pins, two-way, enable low while driving
  input wire logic [WORD_BYTES*8-1:0] data_in,
  output logic [WORD_BYTES*8-1:0] data_out,
  output logic [WORD_BYTES*8-1:0] data_oe_n
);
  localparam int DW = WORD_BYTES * 8;

  logic [1:0] width_q;
  logic valid_pol_q;
  logic vacant_pol_q;
  logic enable_q;
  logic valid_q;
  logic vacant_q;
  logic [DW-1:0] out_word_q;
  logic [DW-1:0] in_word_q;
  logic [pport_pkg::IRQ_BITS-1:0] irq_status_q;
  logic [pport_pkg::IRQ_BITS-1:0] irq_mask_q;
  logic strobe_act_q;
  logic oe_act_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [DW-1:0] lane_mask;
  logic [DW-1:0] drive_q;

  logic strobe_act;
  logic oe_act;
  logic req;
  logic take;
  logic page;
  logic [3:0] off;
  logic wr_data0;
  logic rd_data0;
  logic wr_cfg;
  logic wr_port;
  logic wr_irq;
  logic wr_status;
  logic wr_mask;
  logic rd_fetch;
  logic [pport_pkg::IRQ_BITS-1:0] irq_event;

  // Gated by chip select and by the port enable
  assign strobe_act = enable_q && !chip_select_n && !input_strobe_n;
  assign oe_act = enable_q && !chip_select_n && !output_enable_n;

  // One wait state: the access completes on the cycle after ack_q sets
  assign req = avs_read || avs_write;
  assign take = req && ack_q;
  assign avs_waitrequest = req && !ack_q;
  localparam int ADDR_PAGE_IDX = pport_pkg::ADDR_PAGE_BIT;
  assign page = avs_address[ADDR_PAGE_IDX];
  assign off = {avs_address[3:2], 2'h0};
  // Write decodes, each one cycle wide on the taking edge
  assign wr_port = take && avs_write && !page;
  assign wr_irq = take && avs_write && page;
  assign wr_status = wr_irq && off == pport_pkg::OFF_IRQ_STATUS;
  assign wr_mask = wr_irq && off == pport_pkg::OFF_IRQ_MASK;
  // Read word is fetched in the wait cycle, before the taking edge
  assign rd_fetch = avs_read && !ack_q;
  // Only data0 moves the handshake, so it must be touched last
  assign wr_data0 = take && avs_write && !page &&
                    off == pport_pkg::OFF_DATA0;
  assign rd_data0 = take && avs_read && !page &&
                    off == pport_pkg::OFF_DATA0;
  assign wr_cfg = take && avs_write && !page &&
                  off == pport_pkg::OFF_CONFIG && avs_byteenable[0];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req && !ack_q;
    end
  end

  // Width picks which byte lanes take part
  always_comb begin
    lane_mask = '0;
    for (int i = 0; i < WORD_BYTES; i++) begin
      if (i == 0 || (i == 1 && width_q != pport_pkg::WIDTH_8) ||
          (i == 2 && width_q == pport_pkg::WIDTH_24)) begin
        lane_mask[i*8 +: 8] = 8'hFF;
      end
    end
  end

  // Flag bits 2 and 3 are read-only, so a config write skips them
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      width_q <= pport_pkg::WIDTH_RESET;
    end else if (wr_cfg) begin
      width_q <= avs_writedata[pport_pkg::CFG_WIDTH_LSB +: 2];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      valid_pol_q <= 1'b0;
    end else if (wr_cfg) begin
      valid_pol_q <= avs_writedata[pport_pkg::CFG_VALID_POL];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vacant_pol_q <= 1'b0;
    end else if (wr_cfg) begin
      vacant_pol_q <= avs_writedata[pport_pkg::CFG_VACANT_POL];
    end
  end

  // Port stays idle after reset until firmware turns it on
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enable_q <= 1'b0;
    end else if (wr_cfg) begin
      enable_q <= avs_writedata[pport_pkg::CFG_ENABLE];
    end
  end

  // Output latches, one byte per data register
  genvar g;
  generate
    for (g = 0; g < WORD_BYTES; g++) begin : g_lane
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          out_word_q[g*8 +: 8] <= 8'h00;
        end else if (wr_port && avs_byteenable[0] &&
                     off == 4'(4 * (g + 1))) begin
          out_word_q[g*8 +: 8] <= avs_writedata[7:0];
        end
      end
    end
  endgenerate

  // Input latches follow the pins while strobe is active
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      in_word_q <= '0;
    end else if (strobe_act) begin
      in_word_q <= data_in & lane_mask;
    end
  end

  // Valid: set by data0 write, held until output enable
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      valid_q <= 1'b0;
    end else if (wr_data0) begin
      valid_q <= 1'b1;
    end else if (oe_act) begin
      valid_q <= 1'b0;
    end
  end

  // Vacant: set by data0 read, held until strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vacant_q <= 1'b0;
    end else if (rd_data0) begin
      vacant_q <= 1'b1;
    end else if (strobe_act) begin
      vacant_q <= 1'b0;
    end
  end

  // Pins active high at polarity 0, low at 1
  assign out_word_valid_pin = valid_q ^ valid_pol_q;
  assign latch_vacant_out = vacant_q ^ vacant_pol_q;
  // Push-pull outputs while enabled; else left to the GPIO logic
  assign handshake_oe_n = !enable_q;

  // Drive only while output enable and chip select both low
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      oe_act_q <= 1'b0;
      strobe_act_q <= 1'b0;
      drive_q <= '0;
      data_out <= '0;
    end else begin
      oe_act_q <= oe_act;
      strobe_act_q <= strobe_act;
      drive_q <= oe_act ? lane_mask : '0;
      data_out <= out_word_q & lane_mask;
    end
  end
  assign data_oe_n = ~drive_q;

  // Trailing edges of output enable and strobe
  always_comb begin
    irq_event = '0;
    irq_event[pport_pkg::IRQ_READ_DONE] = oe_act_q && !oe_act;
    irq_event[pport_pkg::IRQ_WRITE_DONE] = strobe_act_q && !strobe_act;
  end

  // Sticky status, write one to clear; an event outranks a same-cycle
  // clear so that no completion is lost to a late acknowledge
  generate
    for (g = 0; g < pport_pkg::IRQ_BITS; g++) begin : g_irq
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          irq_status_q[g] <= 1'b0;
        end else if (irq_event[g]) begin
          irq_status_q[g] <= 1'b1;
        end else if (wr_status && avs_writedata[g]) begin
          irq_status_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_mask_q <= '0;
    end else if (wr_mask) begin
      irq_mask_q <= avs_writedata[pport_pkg::IRQ_BITS-1:0];
    end
  end
  assign irq = |(irq_status_q & irq_mask_q);

  // Read mux; flags read as the inverse of their pins
  always_comb begin
    rdata_d = pport_pkg::UNMAPPED_READ;
    if (!page) begin
      unique case (off)
        pport_pkg::OFF_CONFIG: begin
          rdata_d[pport_pkg::CFG_WIDTH_LSB +: 2] = width_q;
          rdata_d[pport_pkg::CFG_VALID_FLAG] = !(valid_q ^ valid_pol_q);
          rdata_d[pport_pkg::CFG_VACANT_FLAG] =
            !(vacant_q ^ vacant_pol_q);
          rdata_d[pport_pkg::CFG_VALID_POL] = valid_pol_q;
          rdata_d[pport_pkg::CFG_VACANT_POL] = vacant_pol_q;
          rdata_d[pport_pkg::CFG_ENABLE] = enable_q;
        end
        pport_pkg::OFF_DATA0: begin
          rdata_d[7:0] = in_word_q[7:0];
        end
        pport_pkg::OFF_DATA1: begin
          rdata_d[7:0] = 8'(in_word_q >> 8);
        end
        pport_pkg::OFF_DATA2: begin
          rdata_d[7:0] = 8'(in_word_q >> 16);
        end
        default: begin
          rdata_d = pport_pkg::UNMAPPED_READ;
        end
      endcase
    end else if (off == pport_pkg::OFF_IRQ_STATUS) begin
      rdata_d[pport_pkg::IRQ_BITS-1:0] = irq_status_q;
    end else if (off == pport_pkg::OFF_IRQ_MASK) begin
      rdata_d[pport_pkg::IRQ_BITS-1:0] = irq_mask_q;
    end
  end

  // Loaded in the wait cycle so the word stands at the taking edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_fetch) begin
      rdata_q <= rdata_d;
    end
  end
  assign avs_readdata = rdata_q;
endmodule
`default_nettype wire

// ===== design/pport_pkg.sv
// Package for the assisted parallel port block: register map, fields,
// reset values. Assumes a 32-bit Avalon-MM slave with byte offsets.
package pport_pkg;
  // Byte offsets of the slave's registers
  localparam logic [3:0] OFF_CONFIG = 4'h0;
  localparam logic [3:0] OFF_DATA0 = 4'h4;
  localparam logic [3:0] OFF_DATA1 = 4'h8;
  localparam logic [3:0] OFF_DATA2 = 4'hC;
  localparam logic [3:0] OFF_IRQ_STATUS = 4'h0;
  localparam logic [3:0] OFF_IRQ_MASK = 4'h4;
  // Byte address bit selecting the interrupt page
  localparam int ADDR_PAGE_BIT = 4;
  // Config register fields
  localparam int CFG_WIDTH_LSB = 0;
  localparam int CFG_VALID_FLAG = 2;
  localparam int CFG_VACANT_FLAG = 3;
  localparam int CFG_VALID_POL = 4;
  localparam int CFG_VACANT_POL = 5;
  localparam int CFG_ENABLE = 6;
  localparam logic [1:0] WIDTH_RESET = 2'h0;
  // Interrupt status fields
  localparam int IRQ_READ_DONE = 0;
  localparam int IRQ_WRITE_DONE = 1;
  localparam int IRQ_BITS = 2;
  // Width codes
  localparam logic [1:0] WIDTH_8 = 2'h0;
  localparam logic [1:0] WIDTH_16 = 2'h1;
  localparam logic [1:0] WIDTH_24 = 2'h2;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
endpackage

// ===== sim/assisted_parallel_port_checker.sv
// Port-level checks of the assisted parallel port.
// Bound to the design; sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module assisted_parallel_port_checker #(
  parameter int WORD_BYTES = 3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic irq,
  input wire logic input_strobe_n,
  input wire logic output_enable_n,
  input wire logic chip_select_n,
  input wire logic latch_vacant_out,
  input wire logic out_word_valid_pin,
  input wire logic handshake_oe_n,
  input wire logic [WORD_BYTES*8-1:0] data_in,
  input wire logic [WORD_BYTES*8-1:0] data_out,
  input wire logic [WORD_BYTES*8-1:0] data_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence host_rd;
    !output_enable_n && !chip_select_n && !handshake_oe_n;
  endsequence
  sequence bus_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  chk_wait_once: assert property (bus_req |=> !avs_waitrequest)
    else $error("bus wait longer than one cycle");
  chk_wait_first: assert property (
    $rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("bus answered in first cycle");
  chk_unmapped_zero: assert property (
    avs_read && !avs_waitrequest && avs_address == 5'h18
    |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
  chk_drive_start: assert property (
    host_rd |=> data_oe_n[7:0] == 8'h00) else $error("data not driven");
  chk_drive_gated: assert property (
    |(~data_oe_n) |-> $past(!output_enable_n && !chip_select_n))
    else $error("data driven without select");
  chk_drive_release: assert property (
    output_enable_n && $past(output_enable_n) |-> &data_oe_n)
    else $error("data still driven");
  chk_valid_cause: assert property (
    $changed(out_word_valid_pin) |->
    $past(avs_write || !output_enable_n && !chip_select_n))
    else $error("valid pin moved alone");
  chk_vacant_cause: assert property (
    $changed(latch_vacant_out) |->
    $past(avs_write || avs_read || !input_strobe_n && !chip_select_n))
    else $error("vacant pin moved alone");
  chk_push_pull: assert property (
    $changed(handshake_oe_n) |-> $past(avs_write))
    else $error("pin enable moved alone");
endmodule
bind assisted_parallel_port assisted_parallel_port_checker #(
  .WORD_BYTES(WORD_BYTES)) u_chk (.*);
`default_nettype wire

// ===== sim/pport_host_model.sv
// External host: drives select, strobe, output enable, data pins.
// Resolves the shared data pins from both enables.
`timescale 1ns/100ps
`default_nettype none
module pport_host_model (
  input wire logic clk,
  output logic stb_n,
  output logic oe_n,
  output logic cs_n,
  input wire logic [23:0] dout,
  input wire logic [23:0] doe_n,
  output logic [23:0] pins
);
  logic drv = 1'b0;
  logic [23:0] hv = 24'h0;
  logic [23:0] last;
  initial begin
    {stb_n, oe_n, cs_n} = 3'h7;
  end
  // No pull on the pins: released bits show the inverse level
  assign pins = (dout & ~doe_n) | ((drv ? hv : ~last) & doe_n);
  always_ff @(posedge clk) last <= pins;
  task automatic wr(input logic [23:0] v, input logic c);
    @(posedge clk);
    cs_n <= c;
    stb_n <= 1'b0;
    drv <= 1'b1;
    hv <= v;
    repeat (2) @(posedge clk);
    {cs_n, stb_n, drv} <= 3'h6;
    repeat (2) @(posedge clk);
  endtask
  task automatic rd(output logic [23:0] v, output logic [23:0] en);
    @(posedge clk);
    {cs_n, oe_n} <= 2'h0;
    @(posedge clk);
    @(negedge clk);
    v = pins;
    en = ~doe_n;
    @(posedge clk);
    {cs_n, oe_n} <= 2'h3;
    repeat (2) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ===== sim/assisted_parallel_port_bench.sv
// Bench: random words both ways at every width, random polarity per width.
// Host pins from the host model; registers over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
module assisted_parallel_port_bench;
  logic clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, r;
  logic wq, irq, stb_n, oe_n, cs_n, vac, val, hs_n, vp, ep, vs, es;
  logic [23:0] pins, dout, doe_n, word, got, en, m;
  logic [1:0] mask;
  int n_errors = 0, checks = 0;
  always #2 clk = ~clk;
  assisted_parallel_port u_dut (.clk(clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(wq), .irq(irq), .input_strobe_n(stb_n),
    .output_enable_n(oe_n), .chip_select_n(cs_n),
    .latch_vacant_out(vac), .out_word_valid_pin(val),
    .handshake_oe_n(hs_n), .data_in(pins), .data_out(dout),
    .data_oe_n(doe_n));
  pport_host_model u_host (.clk(clk), .stb_n(stb_n), .oe_n(oe_n),
    .cs_n(cs_n), .dout(dout), .doe_n(doe_n), .pins(pins));
  task automatic conclude;
    if (n_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp(input string s, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    {avs_address, avs_write, avs_read, avs_writedata} <= {a, w, !w, d};
    // Waitrequest seen low here is what the next rising edge samples
    do @(negedge clk); while (wq !== 1'b0);
    @(posedge clk);
    r = avs_readdata;
    {avs_write, avs_read} <= 2'h0;
    @(negedge clk);
  endtask
  // Flags read as the inverse of their pins
  function automatic logic [31:0] cfgv(logic e, logic [1:0] w);
    return {25'h0, e, ep, vp, ~(es ^ ep), ~(vs ^ vp), w};
  endfunction
  initial begin
    #100000;
    n_errors++;
    conclude;
  end
  initial begin
    void'($urandom(90));
    {vp, ep, vs, es} = 4'h0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    bus(0, 5'h00, 0);
    cmp("config", cfgv(0, 2'h0), r);
    for (int w = 0; w < 3; w++) begin
      {vp, ep, mask} = $urandom;
      m = 24'hFFFFFF >> (16 - 8 * w);
      bus(1, 5'h00, cfgv(1, w));
      cmp("push pull", 0, hs_n);
      bus(1, 5'h14, mask);
      word = $urandom;
      for (int b = 2; b >= 0; b--) begin
        bus(1, 5'(4 + 4 * b), word[8*b +: 8]);
        vs = (b == 0);
        cmp("valid pin", vs ^ vp, val);
      end
      u_host.rd(got, en);
      vs = 0;
      cmp("host read", word & m, got & m);
      cmp("drive mask", m, en);
      cmp("valid pin", vs ^ vp, val);
      bus(0, 5'h10, 0);
      cmp("status", 1, r);
      cmp("irq", mask[0], irq);
      bus(1, 5'h10, 1);
      u_host.wr($urandom, 1'b1);
      bus(0, 5'h10, 0);
      cmp("status", 0, r);
      word = $urandom;
      u_host.wr(word, 1'b0);
      es = 0;
      cmp("vacant pin", es ^ ep, vac);
      bus(0, 5'h10, 0);
      cmp("status", 2, r);
      cmp("irq", mask[1], irq);
      bus(1, 5'h10, 2);
      for (int b = 2; b >= 0; b--) begin
        bus(0, 5'(4 + 4 * b), 0);
        es = (b == 0);
        cmp("data byte", b <= w ? word[8*b +: 8] : 0, r);
        cmp("vacant pin", es ^ ep, vac);
      end
      bus(0, 5'h00, 0);
      cmp("config", cfgv(1, w), r);
    end
    bus(1, 5'h18, 32'hFFFFFFFF);
    bus(0, 5'h18, 0);
    cmp("unmapped", 0, r);
    conclude;
  end
endmodule
`default_nettype wire
